// ---- tuiab_pkg.sv ----
/*
 * tuiab_pkg: shared constants, types and field layouts for the trace
 * unstable alarm and indirect buffer register bank.
 * Assumes an 8-bit register port with a 12-bit byte address, one clock.
 */
package tuiab_pkg;

    // register port geometry
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [11:0] OFF_TU3_EVENTS  = 12'h0426;
    localparam logic [11:0] OFF_TU4_EVENTS  = 12'h0427;
    localparam logic [11:0] OFF_THRESHOLDS  = 12'h0428;
    localparam logic [11:0] OFF_BUF_SELECT  = 12'h0429;
    localparam logic [11:0] OFF_BYTE_LAUNCH = 12'h042a;
    localparam logic [11:0] OFF_IND_DATA    = 12'h042b;
    localparam logic [11:0] OFF_CONTROL     = 12'h042c;
    localparam logic [11:0] OFF_GRP_MODE_LO = 12'h042d;
    localparam logic [11:0] OFF_GRP_MODE_HI = 12'h042e;

    // field positions
    localparam int unsigned SEL_PAGE_BIT   = 7;
    localparam int unsigned LAUNCH_BUSY    = 7;
    localparam int unsigned LAUNCH_DIR     = 6;
    localparam int unsigned CTL_IRQ_EN     = 0;
    localparam int unsigned CTL_ALGO       = 1;
    localparam int unsigned CTL_PERSISTENCE_SELECT       = 2;
    localparam int unsigned CTL_TU3_MODE   = 3;
    localparam int unsigned CTL_LONG_MSG   = 4;

    // values after reset
    localparam logic [7:0] THRESH_RESET  = 8'h77;
    localparam logic [7:0] SELECT_RESET  = 8'h00;
    localparam logic [6:0] LAUNCH_RESET  = 7'h00;
    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    localparam logic [13:0] GMODE_RESET  = 14'h0000;

    // persistence counts and indirect access length in cycles
    localparam logic [2:0] PERSIST_SHORT = 3'h3;
    localparam logic [2:0] PERSIST_LONG  = 3'h5;
    localparam logic [1:0] IND_ACCESS_CYCLES = 2'h2;

    // geometry of tributaries and buffer
    localparam int unsigned NUM_GROUPS = 7;
    localparam int unsigned NUM_TRIBS  = 28;
    localparam int unsigned BUF_DEPTH  = 4096;

    // per-group tributary mode
    typedef enum logic [1:0] {
        GM_TU11 = 2'b00,
        GM_TU12 = 2'b01,
        GM_VT3  = 2'b10,
        GM_TU2  = 2'b11
    } tuiab_gmode_t;

    // one received trace message, from the extraction datapath
    typedef struct packed {
        logic       valid;
        logic [2:0] group;
        logic [1:0] trib;
        logic       differs;
    } tuiab_msg_t;

    // one captured byte written into the capture page
    typedef struct packed {
        logic       valid;
        logic [2:0] group;
        logic [1:0] trib;
        logic [5:0] addr;
        logic [7:0] data;
    } tuiab_cap_t;

endpackage : tuiab_pkg

// ---- tuiab_top.sv ----
/*
 * tuiab_top: clear-on-read unstable event latches for tributaries 3 and 4
 * of seven groups, unstable thresholds with the per-tributary alarm
 * machine, and the indirect access engine for the trace buffer pages.
 * Assumes the register master and the extraction datapath share core_clk.
 */
// Notes on behaviour
// - latch bit sets on unstable event; register read clears it and acks
// - in TU3 mode all third and fourth tributary bits read zero
// - third-tributary bit reads zero for groups in TU2 or VT3 mode
// - fourth-tributary bit reads zero for groups in TU2, VT3 or TU12 mode
// - event raised on alarm declaration and on alarm removal
// - latches keep capturing with interrupt enable low
// - bits 0 to 6 map groups 1 to 7; bit 7 unused
// - thresholds: short in 3:0, long in 7:4, each resets to 0111
// - algorithm low: count each differing message, alarm when above threshold
// - algorithm high: first difference starts counting every message
// - three or five repeats clear alarm and counter, message accepted
// - select register: group index 4:2, tributary index 1:0
// - page bit 7 high picks capture page, low expected page
// - both pages readable and writable indirectly
// - a write of the launch register while not busy starts one indirect access
// - byte index in bits 5:0 selects the byte in the page
// - direction zero writes data register byte into the buffer
// - direction one reads the buffer byte into the data register
// - busy bit 7 high from launch until the access completes
// - data register keeps software value until a read completes
`timescale 1ns/1ps
module tuiab_top (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // register port
    input  wire logic [11:0]             reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    // extraction datapath
    input  wire tuiab_pkg::tuiab_msg_t   msg_in,
    input  wire tuiab_pkg::tuiab_cap_t   cap_in,
    // status
    output logic      [27:0]             trace_unstable_alarm,
    output logic                         unstable_irq
);

    typedef enum logic [0:0] {
        IND_IDLE   = 1'b0,
        IND_ACCESS = 1'b1
    } tuiab_ind_state_t;

    // which latch bits exist for tributary 3 (pos 0) or 4 (pos 1)
    function automatic logic [6:0] tuiab_live_mask(
        input logic        pos,
        input logic        tu3,
        input logic [13:0] gm
    );
        logic [6:0]   m;
        tuiab_pkg::tuiab_gmode_t g;
        m = 7'h00;
        for (int i = 0; i < 7; i++) begin
            g = tuiab_pkg::tuiab_gmode_t'(gm[2*i +: 2]);
            if (!pos) begin
                m[i] = (g != tuiab_pkg::GM_TU2) &&
                       (g != tuiab_pkg::GM_VT3);
            end else begin
                m[i] = (g == tuiab_pkg::GM_TU11);
            end
        end
        if (tu3) begin
            m = 7'h00;
        end
        return m;
    endfunction : tuiab_live_mask

    // registers
    logic [7:0]  thresh_r;
    logic [7:0]  select_r;
    logic [6:0]  launch_r;
    logic [7:0]  data_r;
    logic [4:0]  control_r;
    logic [13:0] gmode_r;
    logic [6:0]  tu3_evt_r;
    logic [6:0]  tu4_evt_r;
    logic [7:0]  rdata_r;
    logic        busy_r;
    logic [1:0]  ind_cnt_r;
    tuiab_ind_state_t ind_state_r;
    logic [11:0] ind_idx_r;
    logic        ind_dir_r;
    logic [7:0]  buf_mem [tuiab_pkg::BUF_DEPTH];

    // per-tributary alarm machine state
    logic [4:0]  ucnt_r   [tuiab_pkg::NUM_TRIBS];
    logic [2:0]  rep_r    [tuiab_pkg::NUM_TRIBS];
    logic        active_r [tuiab_pkg::NUM_TRIBS];
    logic [27:0] alarm_r;

    logic [6:0]  live3;
    logic [6:0]  live4;
    logic        wr_launch;
    logic        ind_done;
    logic        rd_tu3;
    logic        rd_tu4;
    logic [4:0]  msg_slot;
    logic        msg_ok;
    logic        alarm_nxt;
    logic [4:0]  ucnt_nxt;
    logic [3:0]  thr_sel;
    logic [2:0]  rep_goal;
    logic [6:0]  evt3_set;
    logic [6:0]  evt4_set;

    assign live3 = tuiab_live_mask(1'b0, control_r[tuiab_pkg::CTL_TU3_MODE],
                                   gmode_r);
    assign live4 = tuiab_live_mask(1'b1, control_r[tuiab_pkg::CTL_TU3_MODE],
                                   gmode_r);
    assign rd_tu3 = reg_rd && (reg_addr == tuiab_pkg::OFF_TU3_EVENTS);
    assign rd_tu4 = reg_rd && (reg_addr == tuiab_pkg::OFF_TU4_EVENTS);
    assign wr_launch = reg_wr && (reg_addr == tuiab_pkg::OFF_BYTE_LAUNCH)
                       && !busy_r;

    // software-writable configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            thresh_r  <= tuiab_pkg::THRESH_RESET;
            select_r  <= tuiab_pkg::SELECT_RESET;
            control_r <= tuiab_pkg::CONTROL_RESET;
            gmode_r   <= tuiab_pkg::GMODE_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                tuiab_pkg::OFF_THRESHOLDS: thresh_r <= reg_wdata;
                tuiab_pkg::OFF_BUF_SELECT: begin
                    select_r <= reg_wdata & 8'h9f;
                end
                tuiab_pkg::OFF_CONTROL:     control_r <= reg_wdata[4:0];
                tuiab_pkg::OFF_GRP_MODE_LO: gmode_r[7:0] <= reg_wdata;
                tuiab_pkg::OFF_GRP_MODE_HI: gmode_r[13:8] <= reg_wdata[5:0];
                default: ;
            endcase
        end
    end

    // launch register fields: refused while an access is still running
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            launch_r <= tuiab_pkg::LAUNCH_RESET;
        end else if (wr_launch) begin
            launch_r <= reg_wdata[6:0];
        end
    end

    // indirect engine; a capture write from the datapath in the last access cycle holds it a cycle
    assign ind_done = (ind_state_r == IND_ACCESS) && (ind_cnt_r == 2'h0)
                      && !cap_in.valid;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ind_state_r <= IND_IDLE;
            busy_r      <= 1'b0;
            ind_cnt_r   <= 2'h0;
            ind_idx_r   <= 12'h000;
            ind_dir_r   <= 1'b0;
        end else begin
            unique case (ind_state_r)
                IND_IDLE: begin
                    if (wr_launch) begin
                        ind_state_r <= IND_ACCESS;
                        busy_r      <= 1'b1;
                        ind_cnt_r   <= tuiab_pkg::IND_ACCESS_CYCLES - 2'h1;
                        ind_idx_r   <= {select_r[tuiab_pkg::SEL_PAGE_BIT],
                                        select_r[4:0], reg_wdata[5:0]};
                        ind_dir_r   <= reg_wdata[tuiab_pkg::LAUNCH_DIR];
                    end
                end
                IND_ACCESS: begin
                    if (ind_done) begin
                        ind_state_r <= IND_IDLE;
                        busy_r      <= 1'b0;
                    end else if (ind_cnt_r != 2'h0) begin
                        ind_cnt_r <= ind_cnt_r - 2'h1;
                    end
                end
            endcase
        end
    end

    // buffer pages: page bit high is capture, low is expected
    always_ff @(posedge core_clk) begin
        if (cap_in.valid) begin
            buf_mem[{1'b1, cap_in.group, cap_in.trib, cap_in.addr}] <=
                cap_in.data;
        end else if (ind_done && !ind_dir_r) begin
            buf_mem[ind_idx_r] <= data_r;
        end
    end

    // data register: a completed read overrides a same-cycle cpu write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_r <= tuiab_pkg::DATA_RESET;
        end else if (ind_done && ind_dir_r) begin
            data_r <= buf_mem[ind_idx_r];
        end else if (reg_wr && reg_addr == tuiab_pkg::OFF_IND_DATA) begin
            data_r <= reg_wdata;
        end
    end

    // alarm machine for the tributary that just delivered a message
    assign msg_ok   = msg_in.valid && (msg_in.group != 3'h7);
    assign msg_slot = 5'({msg_in.group, 2'b00}) + 5'({3'h0, msg_in.trib});
    assign thr_sel  = control_r[tuiab_pkg::CTL_LONG_MSG] ? thresh_r[7:4]
                                                         : thresh_r[3:0];
    assign rep_goal = control_r[tuiab_pkg::CTL_PERSISTENCE_SELECT] ?
                      tuiab_pkg::PERSIST_LONG : tuiab_pkg::PERSIST_SHORT;

    always_comb begin
        ucnt_nxt  = ucnt_r[msg_slot];
        alarm_nxt = alarm_r[msg_slot];
        if (msg_in.differs ||
            (control_r[tuiab_pkg::CTL_ALGO] && active_r[msg_slot])) begin
            // saturate so a long unstable spell never wraps to quiet
            if (ucnt_r[msg_slot] != 5'h1f) begin
                ucnt_nxt = ucnt_r[msg_slot] + 5'h01;
            end
        end
        if (ucnt_nxt > {1'b0, thr_sel}) begin
            alarm_nxt = 1'b1;
        end
        if (!msg_in.differs && (rep_r[msg_slot] + 3'h1 >= rep_goal)) begin
            ucnt_nxt  = 5'h00;
            alarm_nxt = 1'b0;
        end
    end

    generate
        for (genvar t = 0; t < tuiab_pkg::NUM_TRIBS; t++) begin : g_trib
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    ucnt_r[t]   <= 5'h00;
                    rep_r[t]    <= 3'h0;
                    active_r[t] <= 1'b0;
                    alarm_r[t]  <= 1'b0;
                end else if (msg_ok && msg_slot == 5'(t)) begin
                    ucnt_r[t]  <= ucnt_nxt;
                    alarm_r[t] <= alarm_nxt;
                    if (msg_in.differs) begin
                        rep_r[t]    <= 3'h0;
                        active_r[t] <= 1'b1;
                    end else if (rep_r[t] + 3'h1 >= rep_goal) begin
                        rep_r[t]    <= 3'h0;
                        active_r[t] <= 1'b0;
                    end else begin
                        rep_r[t] <= rep_r[t] + 3'h1;
                    end
                end
            end
        end
    endgenerate

    // event on any alarm change, for existing latch bits only
    always_comb begin
        evt3_set = 7'h00;
        evt4_set = 7'h00;
        for (int g = 0; g < tuiab_pkg::NUM_GROUPS; g++) begin
            if (msg_ok && msg_in.group == 3'(g) &&
                alarm_nxt != alarm_r[msg_slot]) begin
                evt3_set[g] = (msg_in.trib == 2'h2) && live3[g];
                evt4_set[g] = (msg_in.trib == 2'h3) && live4[g];
            end
        end
    end

    // clear-on-read latches; a same-cycle event survives the read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tu3_evt_r <= 7'h00;
            tu4_evt_r <= 7'h00;
        end else begin
            tu3_evt_r <= (tu3_evt_r & ~{7{rd_tu3}}) | evt3_set;
            tu4_evt_r <= (tu4_evt_r & ~{7{rd_tu4}}) | evt4_set;
        end
    end

    // read data, valid only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                tuiab_pkg::OFF_TU3_EVENTS:
                    rdata_r <= {1'b0, tu3_evt_r & live3};
                tuiab_pkg::OFF_TU4_EVENTS:
                    rdata_r <= {1'b0, tu4_evt_r & live4};
                tuiab_pkg::OFF_THRESHOLDS:  rdata_r <= thresh_r;
                tuiab_pkg::OFF_BUF_SELECT:  rdata_r <= select_r;
                tuiab_pkg::OFF_BYTE_LAUNCH:
                    rdata_r <= {busy_r, launch_r};
                tuiab_pkg::OFF_IND_DATA:    rdata_r <= data_r;
                tuiab_pkg::OFF_CONTROL:     rdata_r <= {3'h0, control_r};
                tuiab_pkg::OFF_GRP_MODE_LO: rdata_r <= gmode_r[7:0];
                tuiab_pkg::OFF_GRP_MODE_HI: rdata_r <= {2'h0, gmode_r[13:8]};
                default:                    rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata = rdata_r;
    assign trace_unstable_alarm = alarm_r;
    // request follows the latches, so reading them clear drops it
    assign unstable_irq = control_r[tuiab_pkg::CTL_IRQ_EN] &&
        (|(tu3_evt_r & live3) || |(tu4_evt_r & live4));

endmodule : tuiab_top

// ---- tuiab_checker.sv ----
/*
 * tuiab_checker: port-level assertions for tuiab_top.
 * Assumes one clock and an async active-high reset; bound at the foot.
 */
`timescale 1ns/1ps
module tuiab_checker (
    // clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst,
    // register port
    input wire logic [11:0]           reg_addr,
    input wire logic [7:0]            reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [7:0]            reg_rdata,
    // datapath and status
    input wire tuiab_pkg::tuiab_msg_t msg_in,
    input wire tuiab_pkg::tuiab_cap_t cap_in,
    input wire logic [27:0]           trace_unstable_alarm,
    input wire logic                  unstable_irq
);
    logic [4:0]  ctl_r;
    logic [13:0] gm_r;
    logic [1:0]  busy_r;
    logic [6:0]  live3;
    logic [6:0]  live4;
    logic        tu3;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // shadow of control and group modes, same edge as the design
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctl_r <= tuiab_pkg::CONTROL_RESET;
            gm_r  <= tuiab_pkg::GMODE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == tuiab_pkg::OFF_CONTROL)
                ctl_r <= reg_wdata[4:0];
            if (reg_addr == tuiab_pkg::OFF_GRP_MODE_LO)
                gm_r[7:0] <= reg_wdata;
            if (reg_addr == tuiab_pkg::OFF_GRP_MODE_HI)
                gm_r[13:8] <= reg_wdata[5:0];
        end
    end

    // access timer; a relaunch while running is dropped
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst)
            busy_r <= 2'h0;
        else if (busy_r == 2'h0 && reg_wr
                 && reg_addr == tuiab_pkg::OFF_BYTE_LAUNCH)
            busy_r <= tuiab_pkg::IND_ACCESS_CYCLES;
        else if (busy_r != 2'h0 && !(busy_r == 2'h1 && cap_in.valid))
            busy_r <= busy_r - 2'h1; // capture in last cycle stretches
    end

    // third tributary lives in TU11/TU12 groups, fourth only in TU11
    assign tu3 = ctl_r[tuiab_pkg::CTL_TU3_MODE];
    always_comb begin
        for (int g = 0; g < 7; g++) begin
            live3[g] = !tu3 && !gm_r[2*g+1];
            live4[g] = !tu3 && gm_r[2*g+:2] == 2'b00;
        end
    end

    a_event_bit7_zero: assert property (
        $past(reg_rd) && $past(reg_addr[11:1]) == 11'h213 |-> !reg_rdata[7])
        else $error("unused event bit 7 read as one");
    a_trib3_dead_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == tuiab_pkg::OFF_TU3_EVENTS
        |-> (reg_rdata[6:0] & ~$past(live3)) == 7'h00)
        else $error("dead third tributary event bit read as one");
    a_trib4_dead_zero: assert property (
        $past(reg_rd) && $past(reg_addr) == tuiab_pkg::OFF_TU4_EVENTS
        |-> (reg_rdata[6:0] & ~$past(live4)) == 7'h00)
        else $error("dead fourth tributary event bit read as one");
    a_read_clears: assert property (
        reg_rd && reg_addr == tuiab_pkg::OFF_TU3_EVENTS && !msg_in.valid ##1
        reg_rd && reg_addr == tuiab_pkg::OFF_TU3_EVENTS && !msg_in.valid
        |=> reg_rdata == 8'h00)
        else $error("event bits survived a read");
    a_irq_drop_clear: assert property (
        reg_rd && reg_addr == tuiab_pkg::OFF_TU3_EVENTS && !msg_in.valid ##1
        reg_rd && reg_addr == tuiab_pkg::OFF_TU4_EVENTS && !msg_in.valid
        |=> !unstable_irq)
        else $error("interrupt stayed high after both reads");
    a_irq_needs_en: assert property (
        unstable_irq |-> ctl_r[tuiab_pkg::CTL_IRQ_EN])
        else $error("interrupt high while disabled");
    a_busy_reported: assert property (
        $past(reg_rd) && $past(reg_addr) == tuiab_pkg::OFF_BYTE_LAUNCH
        |-> reg_rdata[7] == ($past(busy_r) != 2'h0))
        else $error("busy flag does not follow the access");
    a_select_unused: assert property (
        $past(reg_rd) && $past(reg_addr) == tuiab_pkg::OFF_BUF_SELECT
        |-> reg_rdata[6:5] == 2'b00)
        else $error("unused select bits read as one");
    a_alarm_from_msg: assert property (
        trace_unstable_alarm != $past(trace_unstable_alarm)
        |-> $past(msg_in.valid) && (trace_unstable_alarm
        ^ $past(trace_unstable_alarm))
        == 28'h000_0001 << {$past(msg_in.group), $past(msg_in.trib)})
        else $error("alarm moved without a message for it");
endmodule : tuiab_checker

bind tuiab_top tuiab_checker u_checker (
    .core_clk (core_clk), .rst (rst), .reg_addr (reg_addr),
    .reg_wdata (reg_wdata), .reg_wr (reg_wr), .reg_rd (reg_rd),
    .reg_rdata (reg_rdata), .msg_in (msg_in), .cap_in (cap_in),
    .trace_unstable_alarm (trace_unstable_alarm),
    .unstable_irq (unstable_irq));

// ---- tuiab_cpu_model.sv ----
/*
 * tuiab_cpu_model: register master standing in for polling software.
 * Assumes each task is entered after a rising edge of core_clk.
 */
`timescale 1ns/1ps
module tuiab_cpu_model (
    // clock
    input  wire logic        core_clk,
    // register port
    output logic      [11:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata
);
    initial begin
        reg_addr  = 12'h0000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // one strobe cycle; the next call or idle releases it
    task automatic cyc(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= w;
        reg_rd    <= ~w;
        @(posedge core_clk);
    endtask : cyc

    // stale write data is inverted so it never looks meaningful
    task automatic idle();
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_wdata <= ~reg_wdata;
        @(posedge core_clk);
    endtask : idle

    // indirect access, then poll busy under a bound
    task automatic launch(input logic dir, input logic [5:0] b,
                          input logic [7:0] d, output logic ok);
        ok = 1'b0;
        if (!dir)
            cyc(1'b1, tuiab_pkg::OFF_IND_DATA, d);
        cyc(1'b1, tuiab_pkg::OFF_BYTE_LAUNCH, {1'b0, dir, b});
        for (int i = 0; i < 16 && !ok; i++) begin
            cyc(1'b0, tuiab_pkg::OFF_BYTE_LAUNCH, 8'h00);
            #1 ok = !reg_rdata[7];
            idle();
        end
    endtask : launch
endmodule : tuiab_cpu_model

// ---- tuiab_top_tb.sv ----
/*
 * tuiab_top_tb: self-checking bench for tuiab_top.
 * Assumes the package, the cpu model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module tuiab_top_tb;
    logic                  core_clk = 1'b0;
    logic                  rst = 1'b1;
    logic [11:0]           reg_addr;
    logic [7:0]            reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [7:0]            reg_rdata;
    logic [27:0]           alarm;
    logic                  unstable_irq;
    logic                  rd_d = 1'b0;
    logic                  ok;
    tuiab_pkg::tuiab_msg_t msg_in = '0;
    tuiab_pkg::tuiab_cap_t cap_in = '0;
    int                    fail_count = 0;
    int                    n_compared = 0;
    integer                seed = 32'hde37_5b83;
    logic [7:0]            exp_q[$];
    logic [7:0]            d;
    logic [5:0]            b;
    logic [4:0]            s;

    always #2.5 core_clk = ~core_clk;

    tuiab_top u_dut (
        .core_clk (core_clk), .rst (rst), .reg_addr (reg_addr),
        .reg_wdata (reg_wdata), .reg_wr (reg_wr), .reg_rd (reg_rd),
        .reg_rdata (reg_rdata), .msg_in (msg_in), .cap_in (cap_in),
        .trace_unstable_alarm (alarm), .unstable_irq (unstable_irq));
    tuiab_cpu_model u_cpu (
        .core_clk (core_clk), .reg_addr (reg_addr), .reg_wdata (reg_wdata),
        .reg_wr (reg_wr), .reg_rd (reg_rd), .reg_rdata (reg_rdata));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // read answers stand only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (rd_d && exp_q.size() > 0)
            check(reg_rdata, exp_q.pop_front());
        rd_d <= reg_rd;
    end

    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        u_cpu.cyc(1'b0, a, 8'h00);
        exp_q.push_back(x);
        u_cpu.idle();
        #1;
    endtask : rd

    // back-to-back reads with no gap
    task automatic rd2(input logic [11:0] a1, input logic [7:0] x1,
                       input logic [11:0] a2, input logic [7:0] x2);
        exp_q.push_back(x1);
        exp_q.push_back(x2);
        u_cpu.cyc(1'b0, a1, 8'h00);
        u_cpu.cyc(1'b0, a2, 8'h00);
        u_cpu.idle();
        #1;
    endtask : rd2

    task automatic wr(input logic [11:0] a, input logic [7:0] x);
        u_cpu.cyc(1'b1, a, x);
        u_cpu.idle();
    endtask : wr

    // n messages back to back for one tributary
    task automatic send(input logic [2:0] g, input logic [1:0] t,
                        input logic dif, input int n);
        repeat (n) begin
            msg_in <= '{1'b1, g, t, dif};
            @(posedge core_clk);
        end
        msg_in <= '0;
        @(posedge core_clk);
        #1;
    endtask : send

    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // reset values; the unmapped write must vanish
        wr(12'h0425, 8'hff);
        for (int i = 0; i < 8; i++)
            rd(12'h0425 + 12'(i), (i == 3) ? 8'h77 : 8'h00);
        rd(12'h042f, 8'h00);
        $display("test reset values done");
        // counting per differing message, three repeats clear
        wr(tuiab_pkg::OFF_THRESHOLDS, 8'h32);
        rd(tuiab_pkg::OFF_THRESHOLDS, 8'h32);
        wr(tuiab_pkg::OFF_CONTROL, 8'h01);
        send(3'd1, 2'd2, 1'b1, 1);
        send(3'd1, 2'd2, 1'b0, 2);
        send(3'd1, 2'd2, 1'b1, 1);
        check({7'h00, alarm[6]}, 8'h00);
        send(3'd1, 2'd2, 1'b1, 1);
        check({7'h00, alarm[6]}, 8'h01);
        check({7'h00, unstable_irq}, 8'h01);
        rd2(tuiab_pkg::OFF_TU3_EVENTS, 8'h02,
            tuiab_pkg::OFF_TU3_EVENTS, 8'h00);
        check({7'h00, unstable_irq}, 8'h00);
        send(3'd1, 2'd2, 1'b0, 2);
        check({7'h00, alarm[6]}, 8'h01);
        send(3'd1, 2'd2, 1'b0, 1);
        check({7'h00, alarm[6]}, 8'h00);
        check({7'h00, unstable_irq}, 8'h01);
        rd(tuiab_pkg::OFF_TU3_EVENTS, 8'h02);
        $display("test count per difference done");
        // counting per message, long threshold, five repeats, no irq
        wr(tuiab_pkg::OFF_CONTROL, 8'h16);
        send(3'd0, 2'd3, 1'b1, 1);
        send(3'd0, 2'd3, 1'b0, 1);
        check({7'h00, alarm[3]}, 8'h00);
        send(3'd0, 2'd3, 1'b0, 3);
        check({7'h00, alarm[3]}, 8'h01);
        send(3'd0, 2'd3, 1'b0, 1);
        check({7'h00, alarm[3]}, 8'h00);
        check({7'h00, unstable_irq}, 8'h00);
        rd2(tuiab_pkg::OFF_TU3_EVENTS, 8'h00,
            tuiab_pkg::OFF_TU4_EVENTS, 8'h01);
        $display("test count per message done");
        // group modes TU11, TU12, VT3, TU2 then TU3 mode
        wr(tuiab_pkg::OFF_CONTROL, 8'h00);
        wr(tuiab_pkg::OFF_GRP_MODE_LO, 8'he4);
        for (int g = 0; g < 4; g++)
            for (int t = 2; t < 4; t++)
                send(g[2:0], t[1:0], 1'b1, 3);
        rd2(tuiab_pkg::OFF_TU3_EVENTS, 8'h03,
            tuiab_pkg::OFF_TU4_EVENTS, 8'h01);
        wr(tuiab_pkg::OFF_CONTROL, 8'h08);
        send(3'd4, 2'd2, 1'b1, 3);
        send(3'd4, 2'd3, 1'b1, 3);
        rd2(tuiab_pkg::OFF_TU3_EVENTS, 8'h00,
            tuiab_pkg::OFF_TU4_EVENTS, 8'h00);
        $display("test live masks done");
        // indirect write then read on each page, refused relaunch
        for (int p = 0; p < 2; p++) begin
            s = 5'($random(seed));
            b = 6'($random(seed));
            d = 8'($random(seed));
            wr(tuiab_pkg::OFF_BUF_SELECT, {p[0], 2'b11, s});
            rd(tuiab_pkg::OFF_BUF_SELECT, {p[0], 2'b00, s});
            u_cpu.launch(1'b0, b, d, ok);
            check({7'h00, ok}, 8'h01);
            if (!ok)
                complete_run();
            rd(tuiab_pkg::OFF_IND_DATA, d);
            wr(tuiab_pkg::OFF_IND_DATA, ~d);
            u_cpu.cyc(1'b1, tuiab_pkg::OFF_BYTE_LAUNCH, {2'b01, b});
            u_cpu.cyc(1'b1, tuiab_pkg::OFF_BYTE_LAUNCH, {2'b00, ~b});
            u_cpu.idle();
            repeat (2) @(posedge core_clk);
            rd(tuiab_pkg::OFF_BYTE_LAUNCH, {2'b01, b});
            rd(tuiab_pkg::OFF_IND_DATA, d);
        end
        // capture datapath lands on the capture page
        cap_in <= '{1'b1, s[4:2], s[1:0], b, d ^ 8'h5a};
        @(posedge core_clk);
        cap_in <= '0;
        u_cpu.launch(1'b1, b, 8'h00, ok);
        check({7'h00, ok}, 8'h01);
        rd(tuiab_pkg::OFF_IND_DATA, d ^ 8'h5a);
        $display("test indirect access done");
        complete_run();
    end
endmodule : tuiab_top_tb
